/* verilog/vme_ctrl_status_pkg.sv */
// What this block does
// - Every status bit reads one when its signal or condition is asserted.
// - Writes to read-only bits leave all device state unchanged.
// - Watchdog restart: writing one over a zero restarts watchdog; else nothing.
// - Tick clear bit reads zero; writing zero clears tick output high.
// - Timeout flag set by timeout, reset zero, write zero clears it.
// - Read-only bit shows live asserted state of the isolation line.
// - Four read-only bits show live state of level-7 interrupt pins.
// - Writable bit shows whether the device is system controller.
// - Read-only isolation mode indicator, reads one after reset.
// - Power-up indicator reads one only after a power-up reset.
// - Read-only bit reads one once slot identification has completed.
// - Grant status bits read one when pin high and system controller.
// - Software reset bit resets zero; writing one starts system reset.
// - Line assert bit resets zero; one drives the isolation line asserted.
// - Self-isolation bit resets zero; one puts device in isolation mode.
// - Two-bit tick length code, reset three, selects one of four tick periods.
// - Timeout enable resets one; zero disables local timeout detection.
// - Slot-ID step: writing one over a zero increments counter once.
// - Line config resets one; one selects isolation use, zero interrupt.
`default_nettype none

package vme_ctrl_status_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_GENERAL_STATUS_ZERO = 4'h0;
  localparam logic [3:0] IDX_GENERAL_STATUS_ONE  = 4'h1;
  localparam logic [3:0] IDX_GENERAL_CONTROL     = 4'h2;

  // Bit positions shared by the status registers
  localparam int unsigned BIT_WATCHDOG_RESTART   = 7;
  localparam int unsigned BIT_TICK_OUTPUT_CLEAR  = 6;
  localparam int unsigned BIT_LOCAL_TIMEOUT_FLAG = 5;
  localparam int unsigned BIT_SYSTEM_CONTROLLER  = 5;

  localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h1D;

  // Arbitrary neutral value for the revision indicator bit
  localparam logic REVISION_INDICATOR = 1'b1;

  // Tick periods as printed, then cycles at the pclk rate
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_NORM0_US  = 5000;
  localparam int unsigned TICK_NORM1_US  = 10000;
  localparam int unsigned TICK_NORM2_US  = 50000;
  localparam int unsigned TICK_NORM3_US  = 100000;
  localparam int unsigned TICK_FAST0_US  = 200;
  localparam int unsigned TICK_FAST1_US  = 400;
  localparam int unsigned TICK_FAST2_US  = 2000;
  localparam int unsigned TICK_FAST3_US  = 4000;
  localparam int unsigned TICK_NORM0_CYC = TICK_NORM0_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_NORM1_CYC = TICK_NORM1_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_NORM2_CYC = TICK_NORM2_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_NORM3_CYC = TICK_NORM3_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_FAST0_CYC = TICK_FAST0_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_FAST1_CYC = TICK_FAST1_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_FAST2_CYC = TICK_FAST2_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_FAST3_CYC = TICK_FAST3_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W     = 21;

  typedef struct packed {
    logic       software_reset;
    logic       isolation_line_assert;
    logic       self_isolation;
    logic [1:0] tick_length;
    logic       local_timeout_enable;
    logic       slot_id_step_test;
    logic       isolation_line_config;
  } general_control_t;

endpackage

`default_nettype wire

/* verilog/vme_ctrl_status_regs.sv */
// The implementer's own choice: the APB slave port.
`default_nettype none

module vme_ctrl_status_regs #(
  parameter int unsigned TICK_NORM0_CYC = vme_ctrl_status_pkg::TICK_NORM0_CYC,
  parameter int unsigned TICK_NORM1_CYC = vme_ctrl_status_pkg::TICK_NORM1_CYC,
  parameter int unsigned TICK_NORM2_CYC = vme_ctrl_status_pkg::TICK_NORM2_CYC,
  parameter int unsigned TICK_NORM3_CYC = vme_ctrl_status_pkg::TICK_NORM3_CYC,
  parameter int unsigned TICK_FAST1_CYC = vme_ctrl_status_pkg::TICK_FAST1_CYC,
  parameter int unsigned TICK_FAST2_CYC = vme_ctrl_status_pkg::TICK_FAST2_CYC,
  parameter int unsigned TICK_FAST3_CYC = vme_ctrl_status_pkg::TICK_FAST3_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic        irq1_in_n,
  input  wire logic        sysfail_in_n,
  input  wire logic        acfail_in_n,
  input  wire logic        memerr_in_n,
  input  wire logic        nonmaskable_in_n,
  input  wire logic        grant2_in_pin,
  input  wire logic        grant1_in_pin,
  input  wire logic        syscon_strap,
  input  wire logic        powerup_source,
  input  wire logic        slot_id_done_in,
  input  wire logic        local_timeout_event,
  input  wire logic        isolation_exit,
  input  wire logic        tick_fast_mode,
  output var  logic        irq1_out,
  output var  logic        irq1_oe,
  output var  logic        watchdog_restart_pulse,
  output var  logic        tick_clear_pulse,
  output var  logic        system_reset_pulse,
  output var  logic        slot_id_step_pulse,
  output var  logic        isolation_mode,
  output var  logic        system_controller,
  output var  logic        local_timeout_enable,
  output var  logic        isolation_line_config,
  output var  logic [vme_ctrl_status_pkg::TICK_CNT_W-1:0] tick_period_cycles
);
  import vme_ctrl_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                  pready_ff;
  logic [7:0]            prdata_ff;
  logic                  pslverr_ff;
  logic                  wd_ff;
  logic                  lto_ff;
  logic                  system_controller_flag_ff;
  logic                  iso_ff;
  logic                  pwr_ff;
  logic                  cap_done_ff;
  general_control_t      ctl_ff;
  logic                  wd_pulse_ff;
  logic                  tick_clr_ff;
  logic                  software_reset_pulse_ff;
  logic                  step_pulse_ff;
  logic                  irq1_out_ff;
  logic [TICK_CNT_W-1:0] tick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire       setup      = psel & ~penable;
  wire       access     = psel & penable & pready_ff;
  wire [3:0] idx        = paddr[5:2];
  wire       word_ok    = (paddr[1:0] == 2'h0) & (paddr[11:6] == 6'h00);
  wire       hit_s0     = word_ok & (idx == IDX_GENERAL_STATUS_ZERO);
  wire       hit_s1     = word_ok & (idx == IDX_GENERAL_STATUS_ONE);
  wire       hit_ctl    = word_ok & (idx == IDX_GENERAL_CONTROL);
  wire       mapped     = hit_s0 | hit_s1 | hit_ctl;
  wire       wr_s0      = access & pwrite & hit_s0;
  wire       wr_s1      = access & pwrite & hit_s1;
  wire       wr_ctl     = access & pwrite & hit_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // Read values

  // Interrupt pins are active low, grant pins active high; every status bit reads one when asserted
  wire line_state   = ~irq1_in_n;
  wire [3:0] lvl7_state = {~sysfail_in_n, ~acfail_in_n,
                           ~memerr_in_n, ~nonmaskable_in_n};
  wire grant2_state = grant2_in_pin & system_controller_flag_ff;
  wire grant1_state = grant1_in_pin & system_controller_flag_ff;

  // Tick clear bit has no storage and always reads zero
  wire [7:0] general_status_zero_rd = {wd_ff, 1'b0, lto_ff, line_state,
                         lvl7_state};
  wire [7:0] general_status_one_rd = {REVISION_INDICATOR, 1'b0, system_controller_flag_ff, iso_ff, pwr_ff,
                         slot_id_done_in, grant2_state,
                         grant1_state};
  wire [7:0] ctl_rd   = ctl_ff;

  wire [7:0] rd_mux   = hit_s0  ? general_status_zero_rd :
                        hit_s1  ? general_status_one_rd :
                        hit_ctl ? ctl_rd   : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state terms

  // Restart only on a zero-to-one write of the stored bit
  wire wd_fire   = wr_s0 & pwdata[BIT_WATCHDOG_RESTART] & ~wd_ff;
  wire nxt_wd    = wr_s0 ? pwdata[BIT_WATCHDOG_RESTART] : wd_ff;
  wire tick_fire = wr_s0 & ~pwdata[BIT_TICK_OUTPUT_CLEAR];

  // Set wins over a clearing write in the same cycle
  wire lto_set   = local_timeout_event &
                   ctl_ff.local_timeout_enable;
  wire lto_clr   = wr_s0 & ~pwdata[BIT_LOCAL_TIMEOUT_FLAG];
  wire nxt_lto   = lto_set | (lto_ff & ~lto_clr);

  // Status one: only the controller bit is writable
  wire nxt_system_controller_flag  = ~cap_done_ff ? syscon_strap :
                   wr_s1 ? pwdata[BIT_SYSTEM_CONTROLLER] : system_controller_flag_ff;
  wire nxt_pwr   = ~cap_done_ff ? powerup_source : pwr_ff;

  // Isolation held while self or line forces it, else until released
  wire iso_force = ctl_ff.self_isolation |
                   (ctl_ff.isolation_line_config & line_state);
  wire nxt_iso   = iso_force | (iso_ff & ~isolation_exit);

  wire software_reset_fire = wr_ctl & pwdata[7];
  wire step_fire  = wr_ctl & pwdata[1] & ~ctl_ff.slot_id_step_test;
  wire general_control_t nxt_ctl = wr_ctl ? general_control_t'(pwdata[7:0])
                                          : ctl_ff;

  // Tick period select, fast table chosen by the mode input
  wire [2:0] tick_sel = {tick_fast_mode, ctl_ff.tick_length};
  logic [TICK_CNT_W-1:0] nxt_tick;
  always_comb begin
    case (tick_sel)
      3'h0:    nxt_tick = TICK_CNT_W'(TICK_NORM0_CYC);
      3'h1:    nxt_tick = TICK_CNT_W'(TICK_NORM1_CYC);
      3'h2:    nxt_tick = TICK_CNT_W'(TICK_NORM2_CYC);
      3'h3:    nxt_tick = TICK_CNT_W'(TICK_NORM3_CYC);
      3'h4:    nxt_tick = TICK_CNT_W'(TICK_FAST0_CYC);
      3'h5:    nxt_tick = TICK_CNT_W'(TICK_FAST1_CYC);
      3'h6:    nxt_tick = TICK_CNT_W'(TICK_FAST2_CYC);
      default: nxt_tick = TICK_CNT_W'(TICK_FAST3_CYC);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave flops: read data captured in setup, one access cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 8'h00;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      if (setup) begin
        prdata_ff  <= rd_mux;
        pslverr_ff <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  // Strap and power-up source caught once, just after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_done_ff <= 1'b0;
      system_controller_flag_ff     <= 1'b0;
      pwr_ff      <= 1'b0;
    end else begin
      cap_done_ff <= 1'b1;
      system_controller_flag_ff     <= nxt_system_controller_flag;
      pwr_ff      <= nxt_pwr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_ff  <= 1'b0;
      lto_ff <= 1'b0;
      iso_ff <= 1'b1;
      ctl_ff <= GENERAL_CONTROL_RESET;
    end else begin
      wd_ff  <= nxt_wd;
      lto_ff <= nxt_lto;
      iso_ff <= nxt_iso;
      ctl_ff <= nxt_ctl;
    end
  end

  // One-cycle strobes, line drive and tick period towards the engines outside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_pulse_ff    <= 1'b0;
      tick_clr_ff    <= 1'b0;
      software_reset_pulse_ff <= 1'b0;
      step_pulse_ff  <= 1'b0;
      irq1_out_ff    <= 1'b0;
      tick_ff        <= TICK_CNT_W'(TICK_NORM3_CYC);
    end else begin
      wd_pulse_ff    <= wd_fire;
      tick_clr_ff    <= tick_fire;
      software_reset_pulse_ff <= software_reset_fire;
      step_pulse_ff  <= step_fire;
      irq1_out_ff    <= 1'b0;
      tick_ff        <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pready                 = pready_ff;
  assign prdata                 = {24'h000000, prdata_ff};
  assign pslverr                = pslverr_ff;
  // Open-drain line: only ever pulled low, enable follows the assert bit
  assign irq1_out               = irq1_out_ff;
  assign irq1_oe                = ctl_ff.isolation_line_assert;
  assign watchdog_restart_pulse = wd_pulse_ff;
  assign tick_clear_pulse       = tick_clr_ff;
  assign system_reset_pulse     = software_reset_pulse_ff;
  assign slot_id_step_pulse     = step_pulse_ff;
  assign isolation_mode         = iso_ff;
  assign system_controller      = system_controller_flag_ff;
  assign local_timeout_enable   = ctl_ff.local_timeout_enable;
  assign isolation_line_config  = ctl_ff.isolation_line_config;
  assign tick_period_cycles     = tick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire rd_s0_setup = setup & ~pwrite & hit_s0;
  wire rd_s1_setup = setup & ~pwrite & hit_s1;

  property p_lvl7_live;
    rd_s0_setup |=> prdata[3:0] == ~$past({sysfail_in_n, acfail_in_n,
                                           memerr_in_n, nonmaskable_in_n});
  endproperty
  a_lvl7_live: assert property (p_lvl7_live)
    else $error("level-7 pin state read wrong");

  property p_line_live;
    rd_s0_setup |=> prdata[4] == !$past(irq1_in_n) && !prdata[6];
  endproperty
  a_line_live: assert property (p_line_live)
    else $error("isolation line or tick clear read wrong");

  property p_wd_restart;
    wr_s0 && pwdata[7] && !wd_ff |=> watchdog_restart_pulse ##1
                                     !watchdog_restart_pulse || $past(wd_fire);
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog restart strobe missing");

  property p_wd_no_repeat;
    wr_s0 && (wd_ff || !pwdata[7]) |=> !watchdog_restart_pulse;
  endproperty
  a_wd_no_repeat: assert property (p_wd_no_repeat)
    else $error("watchdog restart strobe without edge");

  property p_tick_clear;
    wr_s0 |=> tick_clear_pulse == !$past(pwdata[6]);
  endproperty
  a_tick_clear: assert property (p_tick_clear)
    else $error("tick clear strobe wrong");

  property p_lto_clear;
    lto_clr && !lto_set |=> !lto_ff;
  endproperty
  a_lto_clear: assert property (p_lto_clear)
    else $error("timeout flag not cleared");

  property p_lto_cause;
    $rose(lto_ff) |-> $past(local_timeout_event && ctl_ff.local_timeout_enable);
  endproperty
  a_lto_cause: assert property (p_lto_cause)
    else $error("timeout flag set without enabled timeout");

  property p_grant;
    rd_s1_setup |=> prdata[1:0] == $past({grant2_in_pin & system_controller_flag_ff,
                                          grant1_in_pin & system_controller_flag_ff});
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant status read wrong");

  property p_ro_stable;
    wr_s1 && cap_done_ff |=> $stable(pwr_ff);
  endproperty
  a_ro_stable: assert property (p_ro_stable)
    else $error("read-only power-up bit changed by write");

  property p_self_iso;
    ctl_ff.self_isolation |=> iso_ff;
  endproperty
  a_self_iso: assert property (p_self_iso)
    else $error("self isolation not entered");

  property p_step_once;
    wr_ctl && pwdata[1] |=> slot_id_step_pulse == !$past(ctl_ff.slot_id_step_test);
  endproperty
  a_step_once: assert property (p_step_once)
    else $error("slot id step strobe wrong");

  property p_software_reset;
    wr_ctl |=> system_reset_pulse == $past(pwdata[7]);
  endproperty
  a_software_reset: assert property (p_software_reset)
    else $error("software reset strobe wrong");

  property p_tick_norm3;
    !tick_fast_mode && ctl_ff.tick_length == 2'h3 |=>
      tick_period_cycles == TICK_CNT_W'(TICK_NORM3_CYC);
  endproperty
  a_tick_norm3: assert property (p_tick_norm3)
    else $error("tick period for code three wrong");

  property p_apb_ready;
    setup |=> pready ##1 !pready || $past(setup);
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb ready timing wrong");

  c_read_s0:   cover property (rd_s0_setup ##1 access);
  c_write_ctl: cover property (wr_ctl ##1 system_reset_pulse);
  c_lto_set:   cover property (lto_set ##1 lto_ff);
  c_wd_fire:   cover property (wd_fire ##1 watchdog_restart_pulse);

endmodule

`default_nettype wire

/* tb/vme_pins_model.sv */
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Backplane and card pins around the register block
module vme_pins_model (
  input  wire logic       irq1_out,
  input  wire logic       irq1_oe,
  input  wire logic       other_irq1,
  input  wire logic [3:0] lvl7_req,
  output var  logic       irq1_in_n,
  output var  logic [3:0] lvl7_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pulled-up shared line: low while any party pulls it down
  assign irq1_in_n = !((irq1_oe && !irq1_out) || other_irq1);
  // Interrupt sources drive their pins low when asserted
  assign lvl7_n    = ~lvl7_req;
endmodule

`default_nettype wire

/* tb/testbench.sv */
`default_nettype none

module testbench;
  import vme_ctrl_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] A_ST0 = {6'h00, IDX_GENERAL_STATUS_ZERO, 2'b00};
  localparam logic [11:0] A_ST1 = {6'h00, IDX_GENERAL_STATUS_ONE, 2'b00};
  localparam logic [11:0] A_CTL = {6'h00, IDX_GENERAL_CONTROL, 2'b00};

  logic        pclk                = 1'b0;
  logic        presetn             = 1'b0;
  logic        psel                = 1'b0;
  logic        penable             = 1'b0;
  logic        pwrite              = 1'b0;
  logic [11:0] paddr               = 12'h000;
  logic [31:0] pwdata              = 32'h00000000;
  logic [3:0]  lvl7_req            = 4'h0;
  logic        other_irq1          = 1'b0;
  logic        grant2_in_pin       = 1'b1;
  logic        grant1_in_pin       = 1'b1;
  logic        syscon_strap        = 1'b0;
  logic        powerup_source      = 1'b1;
  logic        slot_id_done_in     = 1'b0;
  logic        local_timeout_event = 1'b0;
  logic        isolation_exit      = 1'b0;
  logic        tick_fast_mode      = 1'b0;
  logic        pready, pslverr, irq1_in_n, irq1_out, irq1_oe;
  logic        isolation_mode, system_controller, local_timeout_enable;
  logic        isolation_line_config, rerr;
  logic [31:0] prdata, rdata;
  logic [3:0]  lvl7_n, pulse;
  logic [20:0] tick_period_cycles;
  int          miscompares     = 0;
  int          samples_checked = 0;
  int          pc[4]           = '{0, 0, 0, 0};
  int          exp_tick[8]     = '{10, 20, TICK_NORM2_CYC, TICK_NORM3_CYC,
                                   TICK_FAST0_CYC, 50, 60, 70};
  logic [11:0] bad[3]          = '{12'h00C, 12'h002, 12'h408};

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  // Short tick counts keep the table walk brief; three rows keep real values
  vme_ctrl_status_regs #(
    .TICK_NORM0_CYC(10), .TICK_NORM1_CYC(20), .TICK_FAST1_CYC(50),
    .TICK_FAST2_CYC(60), .TICK_FAST3_CYC(70)
  ) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .irq1_in_n, .sysfail_in_n(lvl7_n[3]),
    .acfail_in_n(lvl7_n[2]), .memerr_in_n(lvl7_n[1]),
    .nonmaskable_in_n(lvl7_n[0]), .grant2_in_pin, .grant1_in_pin,
    .syscon_strap, .powerup_source, .slot_id_done_in, .local_timeout_event,
    .isolation_exit, .tick_fast_mode, .irq1_out, .irq1_oe,
    .watchdog_restart_pulse(pulse[3]), .tick_clear_pulse(pulse[2]),
    .system_reset_pulse(pulse[1]), .slot_id_step_pulse(pulse[0]),
    .isolation_mode, .system_controller, .local_timeout_enable,
    .isolation_line_config, .tick_period_cycles
  );

  vme_pins_model pins_u (
    .irq1_out, .irq1_oe, .other_irq1, .lvl7_req, .irq1_in_n, .lvl7_n
  );

  always @(posedge pclk)
    for (int i = 0; i < 4; i++)
      if (pulse[i] === 1'b1) pc[i]++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high; no latency assumed
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) miscompares++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdata, {24'h000000, e});
  endtask

  // Two spare edges let registered side effects settle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    chk(rerr, 1'b0);
    repeat (2) @(posedge pclk);
  endtask

  task automatic strobe(input bit iso);
    @(posedge pclk);
    if (iso) isolation_exit <= 1'b1;
    else local_timeout_event <= 1'b1;
    @(posedge pclk);
    isolation_exit <= 1'b0;
    local_timeout_event <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rd(A_CTL, GENERAL_CONTROL_RESET);
    chk(tick_period_cycles, TICK_NORM3_CYC);
    rd(A_ST1, {REVISION_INDICATOR, 7'h18});
    rd(A_ST0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lvl7_req <= 4'h1 << i;
      rd(A_ST0, 8'h01 << i);
    end
    lvl7_req <= 4'h0;
    other_irq1 <= 1'b1;
    rd(A_ST0, 8'h10);
    other_irq1 <= 1'b0;
    strobe(1'b1);
    chk(isolation_mode, 1'b0);
    wr(A_CTL, 8'h5D);
    chk(irq1_oe, 1'b1);
    chk(isolation_mode, 1'b1);
    rd(A_ST0, 8'h10);
    wr(A_CTL, GENERAL_CONTROL_RESET);
    chk(irq1_oe, 1'b0);
    strobe(1'b1);
    rd(A_ST1, 8'h88);
    wr(A_CTL, 8'h3D);
    strobe(1'b1);
    rd(A_ST1, 8'h98);
    wr(A_CTL, GENERAL_CONTROL_RESET);
    strobe(1'b1);
    rd(A_ST1, 8'h88);
    // Line used as plain interrupt must not force isolation
    wr(A_CTL, 8'h1C);
    other_irq1 <= 1'b1;
    strobe(1'b1);
    chk(isolation_mode, 1'b0);
    wr(A_CTL, GENERAL_CONTROL_RESET);
    chk(isolation_mode, 1'b1);
    other_irq1 <= 1'b0;
    strobe(1'b1);
    slot_id_done_in <= 1'b1;
    rd(A_ST1, 8'h8C);
    wr(A_ST1, 8'hFF);
    chk(system_controller, 1'b1);
    rd(A_ST1, 8'hAF);
    grant2_in_pin <= 1'b0;
    rd(A_ST1, 8'hAD);
    grant1_in_pin <= 1'b0;
    rd(A_ST1, 8'hAC);
    grant1_in_pin <= 1'b1;
    wr(A_ST1, 8'h00);
    rd(A_ST1, 8'h8C);
    grant2_in_pin <= 1'b1;
    strobe(1'b0);
    rd(A_ST0, 8'h20);
    wr(A_ST0, 8'h60);
    rd(A_ST0, 8'h20);
    wr(A_ST0, 8'h40);
    rd(A_ST0, 8'h00);
    wr(A_CTL, 8'h19);
    chk(local_timeout_enable, 1'b0);
    strobe(1'b0);
    rd(A_ST0, 8'h00);
    wr(A_ST0, 8'hC0);
    wr(A_ST0, 8'hC0);
    rd(A_ST0, 8'h80);
    wr(A_ST0, 8'h40);
    wr(A_ST0, 8'hC0);
    chk(pc[3], 2);
    wr(A_ST0, 8'h40);
    wr(A_ST0, 8'h00);
    chk(pc[2], 1);
    wr(A_CTL, 8'h9D);
    rd(A_CTL, 8'h9D);
    wr(A_CTL, 8'h1F);
    wr(A_CTL, 8'h1F);
    chk(pc[1], 1);
    chk(pc[0], 1);
    for (int f = 0; f < 2; f++) begin
      tick_fast_mode <= f[0];
      for (int c = 0; c < 4; c++) begin
        wr(A_CTL, 8'h05 | (c[7:0] << 3));
        chk(tick_period_cycles, exp_tick[f*4+c]);
      end
    end
    // Unmapped places answer with an error and change nothing
    wr(A_CTL, GENERAL_CONTROL_RESET);
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 8'h00);
      chk(rerr, 1'b1);
      apb(1'b0, bad[i], 8'h00);
      chk(rdata, 32'h00000000);
    end
    rd(A_CTL, GENERAL_CONTROL_RESET);
    powerup_source <= 1'b0;
    syscon_strap <= 1'b1;
    do_reset();
    rd(A_ST1, 8'hB7);
    rd(A_CTL, GENERAL_CONTROL_RESET);
    report_and_stop();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
endmodule

`default_nettype wire
